// ### verilog/lpbt_consts.vh
// Constants for the LED pulse and breathe timing block
// Summary of operation
// - Period fields are seven bits; each count is 32 ms of period.
// - Zero acts as one (32 ms); 7Fh gives 4064 ms.
// - Pulse one period register resets to 20h, 1024 ms.
// - Bit 7 of pulse one period chooses start on press or on release.
// - Pulse two period register resets to 14h, 640 ms; bit 7 unused.
// - Breathe period register resets to 5Dh, 2976 ms; bit 7 unused.
// - Behaviour code 01b, 10b, 11b picks pulse one, pulse two, breathe period.
// - Periods below 160 ms run at the shortest achievable period.
// - Ramp alert bit set: alert output asserts when a host-driven LED finishes.
// - Only host-actuated activity raises completion alerts, never touch activity.
// - Config bits 5..3: pulse two breath count, n gives n+1.
// - Config bits 2..0: pulse one breath count, n gives n+1.
// - Config register resets to 04h.
// - Each pulse ramps min to max and back within one period.
// - Pulse two repeats while started; on stop runs set count then rests.
// - Breathe ramps up and down each take half the period.
`ifndef LPBT_CONSTS_VH
`define LPBT_CONSTS_VH

// ************************************************************
// Register map
// ************************************************************
`define LPBT_ADDR_P1        8'h84
`define LPBT_ADDR_P2        8'h85
`define LPBT_ADDR_BR        8'h86
`define LPBT_ADDR_CFG       8'h88
`define LPBT_RST_P1         8'h20
`define LPBT_RST_P2         8'h14
`define LPBT_RST_BR         8'h5D
`define LPBT_RST_CFG        8'h04

// ************************************************************
// Field positions
// ************************************************************
`define LPBT_RELEASE_BIT    7
`define LPBT_ALERT_BIT      6
`define LPBT_CNT2_MSB       5
`define LPBT_CNT2_LSB       3
`define LPBT_CNT1_MSB       2
`define LPBT_CNT1_LSB       0
`define LPBT_PER_MSB        6

// ************************************************************
// Behaviour codes
// ************************************************************
`define LPBT_MODE_DIRECT    2'h0
`define LPBT_MODE_PULSE1    2'h1
`define LPBT_MODE_PULSE2    2'h2
`define LPBT_MODE_BREATHE   2'h3

// ************************************************************
// Timing
// ************************************************************
`define LPBT_CLK_HZ         40000000
`define LPBT_TIME_BASE_MS   1
`define LPBT_MS_CYCLES      ((`LPBT_CLK_HZ / 1000) * `LPBT_TIME_BASE_MS)
`define LPBT_STEP_MS        32
`define LPBT_RAMP_STEPS     32
`define LPBT_MIN_PERIOD_MS  160
`define LPBT_MIN_PER        7'h05
`define LPBT_RAMP_LAST      5'h1F

`endif

// ### verilog/lpbt_tick.v
// Millisecond time base prescaler for the LED timing block
module lpbt_tick
#(
   parameter TICK_CYCLES = 40000
)
(
   input  wire        clk_i,
   input  wire        rst_n_i,
   output reg         tick_o
);

   reg  [23:0] cnt_r;

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r  <= 24'h000000;
         tick_o <= 1'b0;
      end
      else if (cnt_r == TICK_CYCLES[23:0] - 24'h000001)
      begin
         cnt_r  <= 24'h000000;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 24'h000001;
         tick_o <= 1'b0;
      end
   end

endmodule

// ### verilog/lpbt_top.v
// LED pulse and breathe timing engine with its period and config registers
`include "lpbt_consts.vh"

module lpbt_top
#(
   parameter MS_CYCLES = `LPBT_MS_CYCLES,
   parameter CHANNELS  = 3
)
(
   input  wire                  clk_i,
   input  wire                  rst_n_i,
   input  wire [7:0]            reg_addr_i,
   input  wire                  reg_wr_i,
   input  wire [7:0]            reg_wdata_i,
   input  wire                  reg_rd_i,
   output reg  [7:0]            reg_rdata_o,
   input  wire [2*CHANNELS-1:0] led_behaviour_select_i,
   input  wire [CHANNELS-1:0]   led_linked_i,
   input  wire [CHANNELS-1:0]   touch_i,
   input  wire [CHANNELS-1:0]   led_drive_i,
   output wire [CHANNELS-1:0]   led_pwm_o,
   output wire [CHANNELS-1:0]   led_busy_o,
   output wire                  alert_n_o
);

   localparam ST_IDLE = 2'b01;
   localparam ST_RUN  = 2'b10;

   // ************************************************************
   // Registers
   // ************************************************************
   reg  [7:0]          pulse_one_period_r;
   reg  [6:0]          pulse_two_period_r;
   reg  [6:0]          breathe_period_r;
   reg  [6:0]          led_behaviour_config_r;
   reg                 alert_r;
   reg  [3:0]          pwm_cnt_r;
   wire                ms_tick;
   wire [CHANNELS-1:0] done_host;

   wire                pulse_start_on_release = pulse_one_period_r[`LPBT_RELEASE_BIT];
   wire [6:0]          pulse_one_period_field = pulse_one_period_r[`LPBT_PER_MSB:0];
   wire                ramp_alert             = led_behaviour_config_r[`LPBT_ALERT_BIT];
   wire [2:0]          pulse_two_breath_count =
      led_behaviour_config_r[`LPBT_CNT2_MSB:`LPBT_CNT2_LSB];
   wire [2:0]          pulse_one_breath_count =
      led_behaviour_config_r[`LPBT_CNT1_MSB:`LPBT_CNT1_LSB];

   // Period in milliseconds per ramp step for a behaviour code
   function [6:0] lpbt_per;
      input [1:0] mode;
      input [6:0] p1;
      input [6:0] p2;
      input [6:0] pb;
      reg   [6:0] raw;
      begin
         case (mode)
            `LPBT_MODE_PULSE1: raw = p1;
            `LPBT_MODE_PULSE2: raw = p2;
            default:           raw = pb;
         endcase
         if (raw == 7'h00)
            raw = 7'h01;
         // Short periods cannot resolve the full ramp, so they are held at the floor
         if (raw < `LPBT_MIN_PER)
            raw = `LPBT_MIN_PER;
         lpbt_per = raw;
      end
   endfunction

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pulse_one_period_r     <= `LPBT_RST_P1;
         pulse_two_period_r     <= 7'h14;
         breathe_period_r       <= 7'h5D;
         led_behaviour_config_r <= 7'h04;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `LPBT_ADDR_P1:  pulse_one_period_r     <= reg_wdata_i;
            `LPBT_ADDR_P2:  pulse_two_period_r     <= reg_wdata_i[6:0];
            `LPBT_ADDR_BR:  breathe_period_r       <= reg_wdata_i[6:0];
            `LPBT_ADDR_CFG: led_behaviour_config_r <= reg_wdata_i[6:0];
            default:        pulse_one_period_r     <= pulse_one_period_r;
         endcase
      end
   end

   // Read data registered; unused bit 7 and unmapped addresses read zero
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            `LPBT_ADDR_P1:  reg_rdata_o <= pulse_one_period_r;
            `LPBT_ADDR_P2:  reg_rdata_o <= {1'b0, pulse_two_period_r};
            `LPBT_ADDR_BR:  reg_rdata_o <= {1'b0, breathe_period_r};
            `LPBT_ADDR_CFG: reg_rdata_o <= {1'b0, led_behaviour_config_r};
            default:        reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Alert: held until the config register is read; a new event wins
   // ************************************************************
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         alert_r <= 1'b0;
      else if (ramp_alert && (|done_host))
         alert_r <= 1'b1;
      else if (reg_rd_i && (reg_addr_i == `LPBT_ADDR_CFG))
         alert_r <= 1'b0;
   end

   assign alert_n_o = ~alert_r;

   // ************************************************************
   // Time base and PWM carrier
   // ************************************************************
   lpbt_tick #(
      .TICK_CYCLES (MS_CYCLES)
   ) u_tick (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .tick_o  (ms_tick)
   );

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pwm_cnt_r <= 4'h0;
      else
         pwm_cnt_r <= pwm_cnt_r + 4'h1;
   end

   // ************************************************************
   // Channel engines
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1)
      begin : gen_chan
         reg  [1:0] state_r;
         reg  [1:0] mode_r;
         reg  [6:0] per_r;
         reg  [6:0] ms_cnt_r;
         reg  [4:0] sub_r;
         reg  [2:0] left_r;
         reg        stop_r;
         reg        act_r;
         reg        host_r;
         reg        done_r;
         reg        pwm_r;
         wire [1:0] mode = led_behaviour_select_i[2*g+1:2*g];
         wire       act  = led_linked_i[g] ? touch_i[g] : led_drive_i[g];
         wire       rise = act & ~act_r;
         wire       fall = ~act & act_r;
         wire       p1_start = pulse_start_on_release ? fall : rise;
         wire       start =
            ((mode == `LPBT_MODE_PULSE1) && p1_start) ||
            (((mode == `LPBT_MODE_PULSE2) || (mode == `LPBT_MODE_BREATHE)) && rise);
         wire       step_end = ms_tick && (ms_cnt_r == per_r - 7'h01);
         wire       breath_end = step_end && (sub_r == `LPBT_RAMP_LAST);
         // Rising half first, falling half second, equal step counts
         wire [3:0] ramp_lvl = sub_r[4] ? ~sub_r[3:0] : sub_r[3:0];
         wire [3:0] lvl =
            state_r[1] ? ramp_lvl :
            ((mode == `LPBT_MODE_DIRECT) && act) ? 4'hF : 4'h0;

         always @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               state_r  <= ST_IDLE;
               mode_r   <= `LPBT_MODE_DIRECT;
               per_r    <= 7'h01;
               ms_cnt_r <= 7'h00;
               sub_r    <= 5'h00;
               left_r   <= 3'h0;
               stop_r   <= 1'b0;
               act_r    <= 1'b0;
               host_r   <= 1'b0;
               done_r   <= 1'b0;
               pwm_r    <= 1'b0;
            end
            else
            begin
               act_r  <= act;
               done_r <= 1'b0;
               pwm_r  <= (lvl > pwm_cnt_r);
               case (state_r)
                  ST_IDLE:
                  begin
                     ms_cnt_r <= 7'h00;
                     sub_r    <= 5'h00;
                     stop_r   <= 1'b0;
                     if (start)
                     begin
                        state_r <= ST_RUN;
                        mode_r  <= mode;
                        per_r   <= lpbt_per(mode, pulse_one_period_field,
                                            pulse_two_period_r, breathe_period_r);
                        host_r  <= ~led_linked_i[g];
                        left_r  <= pulse_one_breath_count;
                     end
                  end
                  ST_RUN:
                  begin
                     if ((mode_r == `LPBT_MODE_BREATHE) && fall)
                     begin
                        state_r <= ST_IDLE;
                        done_r  <= 1'b1;
                     end
                     else
                     begin
                        if (step_end)
                        begin
                           ms_cnt_r <= 7'h00;
                           sub_r    <= sub_r + 5'h01;
                        end
                        else if (ms_tick)
                           ms_cnt_r <= ms_cnt_r + 7'h01;
                        if (breath_end && ((mode_r == `LPBT_MODE_PULSE1) || stop_r))
                        begin
                           if (left_r == 3'h0)
                           begin
                              state_r <= ST_IDLE;
                              done_r  <= 1'b1;
                           end
                           else
                              left_r <= left_r - 3'h1;
                        end
                        // Stop while pulsing: the breath under way is the first of the tail
                        if ((mode_r == `LPBT_MODE_PULSE2) && fall && !stop_r)
                        begin
                           stop_r <= 1'b1;
                           left_r <= pulse_two_breath_count;
                        end
                     end
                  end
                  default:
                     state_r <= ST_IDLE;
               endcase
            end
         end

         assign done_host[g]  = done_r & host_r;
         assign led_pwm_o[g]  = pwm_r;
         assign led_busy_o[g] = state_r[1];
      end
   endgenerate

endmodule

// ### test/lpbt_host_model.sv
// Host register master model for the internal register strobe port
module lpbt_host_model
(
   input  wire        clk_i,
   input  wire  [7:0] reg_rdata_i,
   output logic [7:0] reg_addr_o,
   output logic       reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic       reg_rd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end
   // Entered at a falling edge; a released bus shows the inverse, never the last value
   // An idle cycle follows each transfer so no strobe is lowered and raised in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
      @(negedge clk_i);
   endtask
endmodule

// ### test/lpbt_properties.sv
// Port-level assertions for the LED timing engine
module lpbt_properties
#(
   parameter MS_CYCLES = 4,
   parameter CHANNELS  = 3
)
(
   input wire                  clk_i,
   input wire                  rst_n_i,
   input wire [7:0]            reg_addr_i,
   input wire                  reg_wr_i,
   input wire [7:0]            reg_wdata_i,
   input wire                  reg_rd_i,
   input wire [7:0]            reg_rdata_o,
   input wire [2*CHANNELS-1:0] led_behaviour_select_i,
   input wire [CHANNELS-1:0]   led_linked_i,
   input wire [CHANNELS-1:0]   touch_i,
   input wire [CHANNELS-1:0]   led_drive_i,
   input wire [CHANNELS-1:0]   led_pwm_o,
   input wire [CHANNELS-1:0]   led_busy_o,
   input wire                  alert_n_o
);
   wire act0   = led_linked_i[0] ? touch_i[0] : led_drive_i[0];
   wire mapped = reg_addr_i inside {8'h84, 8'h85, 8'h86, 8'h88};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   unmapped_zero_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   spare_bit_a: assert property (reg_rd_i && mapped && reg_addr_i != 8'h84 |=> !reg_rdata_o[7])
      else $error("unused bit 7 read as one");
   cfg_write_a: assert property (reg_wr_i && reg_addr_i == 8'h88 ##2 reg_rd_i && reg_addr_i == 8'h88
      |=> reg_rdata_o[6:0] == $past(reg_wdata_i[6:0], 3))
      else $error("config write not read back");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   start_cause_a: assert property ($rose(led_busy_o[0]) |-> $past(act0) != $past(act0, 2))
      else $error("channel started without a trigger edge");
   breath_min_a: assert property ($rose(led_busy_o[0]) |-> led_busy_o[0] [*8])
      else $error("run shorter than eight cycles");
   idle_dark_a: assert property (!led_busy_o[0] && !$past(led_busy_o[0])
      && led_behaviour_select_i[1:0] != 2'h0 && $past(led_behaviour_select_i[1:0]) != 2'h0
      |-> !led_pwm_o[0])
      else $error("idle timed channel drives pwm");
   alert_cause_a: assert property ($fell(alert_n_o)
      |-> ($past(led_busy_o, 2) & ~$past(led_busy_o)) != 0)
      else $error("alert without a finished run");
   alert_clear_a: assert property ($rose(alert_n_o) |-> $past(reg_rd_i) && $past(reg_addr_i) == 8'h88)
      else $error("alert cleared without config read");
   alert_hold_a: assert property (!alert_n_o && !reg_rd_i |=> !alert_n_o)
      else $error("alert dropped by itself");
endmodule
bind lpbt_top lpbt_properties #(.MS_CYCLES(MS_CYCLES), .CHANNELS(CHANNELS)) u_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .led_behaviour_select_i(led_behaviour_select_i), .led_linked_i(led_linked_i),
   .touch_i(touch_i), .led_drive_i(led_drive_i), .led_pwm_o(led_pwm_o),
   .led_busy_o(led_busy_o), .alert_n_o(alert_n_o));

// ### test/testbench.sv
// Self-checking bench for the LED timing engine
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 4;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [5:0] sel = 6'h00;
   logic [2:0] lnk = 3'h0;
   logic [2:0] touch = 3'h0;
   logic [2:0] drive = 3'h0;
   wire  [7:0] addr, wdata, rdata;
   wire        wr, rd, alert_n;
   wire  [2:0] pwm, busy;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   lpbt_host_model u_host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
   lpbt_top #(.MS_CYCLES(MS), .CHANNELS(3)) u_lpbt_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .led_behaviour_select_i(sel), .led_linked_i(lnk),
      .touch_i(touch), .led_drive_i(drive), .led_pwm_o(pwm), .led_busy_o(busy),
      .alert_n_o(alert_n));
   // ************************************************************
   // Checking helpers
   // ************************************************************
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Short fields run at the achievable floor of five milliseconds per step
   function automatic int eff(input logic [6:0] p);
      eff = (p < 7'h05) ? 5 : int'(p);
   endfunction
   task automatic wait_busy(input int ch, input logic v);
      int k;
      for (k = 0; k < 9000 && busy[ch] !== v; k++)
         @(negedge clk_i);
      if (busy[ch] !== v)
         check("busy_wait", 32'h0, 32'h1);
   endtask
   task automatic act(input int ch, input logic v);
      if (lnk[ch])
         touch[ch] = v;
      else
         drive[ch] = v;
   endtask
   // One timed run; the trigger is released half a breath after it is applied
   task automatic run(input int ch, input logic [1:0] m, input logic lk, input logic trg,
                      input logic aen, input logic [2:0] c1, input logic [2:0] c2,
                      input logic [6:0] p1);
      logic [6:0] p2;
      logic [6:0] pb;
      logic [7:0] r;
      int b;
      int t0;
      int n;
      int e;
      p2 = 7'h05 + 7'($urandom % 3);
      pb = 7'h05 + 7'($urandom % 3);
      u_host.wr(8'h84, {trg, p1});
      u_host.wr(8'h85, {1'b0, p2});
      u_host.wr(8'h86, {1'b0, pb});
      u_host.wr(8'h88, {1'b0, aen, c2, c1});
      b = 32 * MS * eff(m == 2'h1 ? p1 : (m == 2'h2 ? p2 : pb));
      sel[2*ch +: 2] = m;
      lnk[ch] = lk;
      @(negedge clk_i);
      act(ch, 1'b1);
      if (!trg)
      begin
         wait_busy(ch, 1'b1);
         t0 = cyc;
      end
      repeat (b / 2) @(negedge clk_i);
      if (trg)
         check("idle_before_release", busy[ch], 1'b0);
      act(ch, 1'b0);
      if (trg)
      begin
         wait_busy(ch, 1'b1);
         t0 = cyc;
      end
      wait_busy(ch, 1'b0);
      n = cyc - t0;
      e = (m == 2'h3) ? b / 2 : (int'(m == 2'h1 ? c1 : c2) + 1) * b;
      check("run_length", n >= e - 3 && n <= e + 3, 1'b1);
      @(negedge clk_i);
      check("alert_n", alert_n, !(aen && !lk));
      u_host.rd(8'h88, r);
      check("cfg_read", r, {1'b0, aen, c2, c1});
      check("alert_clear", alert_n, 1'b1);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      logic [7:0] ad [5];
      logic [7:0] rv [5];
      logic [7:0] r;
      logic [7:0] d;
      int seed;
      int cnt;
      ad = '{8'h84, 8'h85, 8'h86, 8'h88, 8'h87};
      rv = '{8'h20, 8'h14, 8'h5D, 8'h04, 8'h00};
      seed = $urandom(79354);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         u_host.rd(ad[i], r);
         check("reset_value", r, rv[i]);
      end
      for (int i = 0; i < 5; i++)
      begin
         d = 8'($urandom);
         u_host.wr(ad[i], d);
         u_host.rd(ad[i], r);
         check("readback", r, i == 0 ? d : (i == 4 ? 8'h00 : {1'b0, d[6:0]}));
      end
      run(0, 2'h1, 1'b0, 1'b0, 1'b1, 3'h0, 3'h0, 7'h00);
      run(1, 2'h1, 1'b0, 1'b1, 1'b1, 3'($urandom % 3), 3'h0, 7'h06);
      run(2, 2'h1, 1'b1, 1'b0, 1'b1, 3'h4, 3'h0, 7'h05);
      run(0, 2'h2, 1'b0, 1'b0, 1'b0, 3'h1, 3'($urandom % 3), 7'h7F);
      run(1, 2'h3, 1'b1, 1'b0, 1'b1, 3'h2, 3'h1, 7'h05);
      run(2, 2'h3, 1'b0, 1'b0, 1'b1, 3'h0, 3'h0, 7'h05);
      // Direct code: full level while driven, dark once released, never a timed run
      sel[1:0] = 2'h0;
      drive[0] = 1'b1;
      repeat (2) @(negedge clk_i);
      cnt = 0;
      repeat (16)
      begin
         @(negedge clk_i);
         cnt = cnt + int'(pwm[0]);
      end
      check("direct_on", cnt, 15);
      check("direct_busy", busy[0], 1'b0);
      drive[0] = 1'b0;
      repeat (2) @(negedge clk_i);
      cnt = 0;
      repeat (16)
      begin
         @(negedge clk_i);
         cnt = cnt + int'(pwm[0]);
      end
      check("direct_off", cnt, 0);
      finish_test();
   end
   // Sized well above the longest expected run sequence
   initial
   begin
      repeat (90000) @(posedge clk_i);
      errors++;
      finish_test();
   end
endmodule
